// File: rtl/ddr2_guard_pkg.sv
package ddr2_guard_pkg;

	// Controller clock
	localparam int REF_CLK_PS = 20000;

	// Device clock made by an external PLL from the controller clock
	localparam int DDR_CK_PS    = 5000;
	localparam int CK_MIN_PS    = 2500;
	localparam int CK_MAX_PS    = 8000;
	localparam int CK_MIN_667PS = 3000;
	localparam int CK_MIN_533PS = 3750;
	localparam int CK_MIN_400PS = 5000;
	localparam bit CK_LEGAL     = (DDR_CK_PS >= CK_MIN_PS) && (DDR_CK_PS <= CK_MAX_PS);

	// Times in picoseconds except MRD_CK in device clocks and DQSS_QTR_CK in quarter clocks, figures of the slower grades where they are the larger
	localparam int RFC_PS      = 105000;
	localparam int REFI_PS     = 7800000;
	localparam int RCD_PS      = 15000;
	localparam int RP_PS       = 15000;
	localparam int RC_PS       = 60000;
	localparam int RAS_PS      = 45000;
	localparam int RAS_MAX_PS  = 70000000;
	localparam int RRD_1KB_PS  = 7500;
	localparam int RRD_2KB_PS  = 10000;
	localparam int FAW_PS      = 50000;
	localparam int MRD_CK      = 2;
	localparam int DQSS_QTR_CK = 0;

	// Least times round up, longest times round down
	localparam logic [3:0]  RFC_CYC     = 4'((RFC_PS + REF_CLK_PS - 1) / REF_CLK_PS);
	localparam logic [8:0]  REFI_CYC    = 9'(REFI_PS / REF_CLK_PS);
	localparam logic [11:0] RCD_CYC     = 12'((RCD_PS + REF_CLK_PS - 1) / REF_CLK_PS);
	localparam logic [3:0]  RP_CYC      = 4'((RP_PS + REF_CLK_PS - 1) / REF_CLK_PS);
	localparam logic [11:0] RC_CYC      = 12'((RC_PS + REF_CLK_PS - 1) / REF_CLK_PS);
	localparam logic [11:0] RAS_CYC     = 12'((RAS_PS + REF_CLK_PS - 1) / REF_CLK_PS);
	localparam logic [11:0] RAS_MAX_CYC = 12'(RAS_MAX_PS / REF_CLK_PS);
	localparam int          RRD_PS      = (RRD_2KB_PS > RRD_1KB_PS) ? RRD_2KB_PS : RRD_1KB_PS;
	localparam logic [3:0]  RRD_CYC     = 4'((RRD_PS + REF_CLK_PS - 1) / REF_CLK_PS);
	localparam int          FAW_CYC     = (FAW_PS + REF_CLK_PS - 1) / REF_CLK_PS;
	localparam logic [3:0]  MRD_CYC     = 4'((MRD_CK * DDR_CK_PS + REF_CLK_PS - 1) / REF_CLK_PS);
	localparam logic [3:0]  SAT4        = 4'hf;
	localparam int          FAW_LIMIT   = 4;
	localparam int          NUM_BANKS   = 4;
	localparam int          PRE_ALL_BIT = 10;

	typedef enum logic [2:0] {
		CMD_NOP   = 3'h0,
		CMD_ACT   = 3'h1,
		CMD_READ  = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_PRE   = 3'h4,
		CMD_REF   = 3'h5,
		CMD_MRS   = 3'h6
	} cmd_t;

	// Pin codes: chip select, row strobe, column strobe, write enable
	localparam logic [3:0] PINS_DESEL = 4'hf;
	localparam logic [3:0] PINS_NOP   = 4'h7;
	localparam logic [3:0] PINS_ACT   = 4'h3;
	localparam logic [3:0] PINS_READ  = 4'h5;
	localparam logic [3:0] PINS_WRITE = 4'h4;
	localparam logic [3:0] PINS_PRE   = 4'h2;
	localparam logic [3:0] PINS_REF   = 4'h1;
	localparam logic [3:0] PINS_MRS   = 4'h0;

endpackage

// File: rtl/bank_timer.sv
`timescale 1ns/1ps
module bank_timer import ddr2_guard_pkg::*; (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	// Commands taken for this bank
	input  wire logic act_i,
	input  wire logic pre_i,
	// Bank state
	output logic      open_o,
	output logic      act_ok_o,
	output logic      access_ok_o,
	output logic      pre_ok_o,
	output logic      idle_ok_o,
	output logic      overdue_o
);

	typedef struct packed {
		logic        open;
		logic [11:0] since_act;
		logic [3:0]  since_pre;
	} bank_state_t;

	bank_state_t s;
	bank_state_t next_s;

	// Counters hold the distance to the edge now being decided, so a fresh
	// command starts them at one
	always_comb begin
		next_s = s;
		if (s.since_act < RAS_MAX_CYC) begin
			next_s.since_act = s.since_act + 12'h001;
		end
		if (s.since_pre != SAT4) begin
			next_s.since_pre = s.since_pre + 4'h1;
		end
		if (act_i) begin
			next_s.open = 1'b1;
			next_s.since_act = 12'h001;
		end else if (pre_i && s.open) begin
			next_s.open = 1'b0;
			next_s.since_pre = 4'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s <= '{open: 1'b0, since_act: RAS_MAX_CYC, since_pre: SAT4};
		end else begin
			s <= next_s;
		end
	end

	assign open_o = s.open;
	assign act_ok_o = !s.open && (s.since_pre >= RP_CYC) && (s.since_act >= RC_CYC);
	assign access_ok_o = s.open && (s.since_act >= RCD_CYC);
	assign pre_ok_o = !s.open || (s.since_act >= RAS_CYC);
	assign idle_ok_o = !s.open && (s.since_pre >= RP_CYC);
	assign overdue_o = s.open && (s.since_act >= RAS_MAX_CYC);

	row_min_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		act_i |=> !pre_i [*2])
		else $error("row closed before least active time");

endmodule

// File: rtl/ddr2_command_timing_guard.sv
`timescale 1ns/1ps
module ddr2_command_timing_guard import ddr2_guard_pkg::*; (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Command request
	input  wire logic        cmd_valid_i,
	input  wire cmd_t        cmd_i,
	input  wire logic [1:0]  bank_i,
	input  wire logic [12:0] addr_i,
	output logic             cmd_accept_o,
	// Device command pins
	output logic             cs_n_o,
	output logic             ras_n_o,
	output logic             cas_n_o,
	output logic             we_n_o,
	output logic [1:0]       ba_o,
	output logic [12:0]      addr_o,
	// Status
	output logic             write_start_o,
	output logic             refresh_due_o,
	output logic [3:0]       row_overdue_o
);

	typedef struct packed {
		logic [3:0]         pins;
		logic [1:0]         ba;
		logic [12:0]        addr;
		logic               accept;
		logic               write_start;
		logic               refresh_due;
		logic [3:0]         overdue;
		logic [3:0]         since_ref;
		logic [3:0]         since_mrs;
		logic [3:0]         since_act;
		logic [FAW_CYC-1:0] faw;
		logic [8:0]         refi;
	} guard_state_t;

	guard_state_t s;
	guard_state_t next_s;

	logic [3:0] act_b;
	logic [3:0] pre_b;
	logic [3:0] open_b;
	logic [3:0] act_ok_b;
	logic [3:0] access_ok_b;
	logic [3:0] pre_ok_b;
	logic [3:0] idle_ok_b;
	logic [3:0] overdue_b;
	logic       legal;
	logic       take;
	logic       mrs_ok;
	logic       ref_ok;
	logic       pre_all;

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			assign act_b[b] = take && (cmd_i == CMD_ACT) && (bank_i == 2'(b));
			assign pre_b[b] = take && (cmd_i == CMD_PRE) && (pre_all || bank_i == 2'(b));
			bank_timer i_bank_timer (
				.ref_clk_i   (ref_clk_i),
				.reset_i     (reset_i),
				.act_i       (act_b[b]),
				.pre_i       (pre_b[b]),
				.open_o      (open_b[b]),
				.act_ok_o    (act_ok_b[b]),
				.access_ok_o (access_ok_b[b]),
				.pre_ok_o    (pre_ok_b[b]),
				.idle_ok_o   (idle_ok_b[b]),
				.overdue_o   (overdue_b[b])
			);
		end
	endgenerate

	assign pre_all = addr_i[PRE_ALL_BIT];
	assign mrs_ok = s.since_mrs >= MRD_CYC;
	assign ref_ok = s.since_ref >= RFC_CYC;

	always_comb begin
		unique case (cmd_i)
			CMD_NOP: legal = mrs_ok;
			CMD_ACT: legal = mrs_ok && ref_ok && act_ok_b[bank_i]
				&& (s.since_act >= RRD_CYC)
				&& ($countones(s.faw[FAW_CYC-2:0]) < FAW_LIMIT);
			CMD_READ, CMD_WRITE: legal = mrs_ok && access_ok_b[bank_i];
			CMD_PRE: legal = mrs_ok && (pre_all ? &pre_ok_b : pre_ok_b[bank_i]);
			CMD_REF, CMD_MRS: legal = mrs_ok && ref_ok && (&idle_ok_b);
			default: legal = 1'b0;
		endcase
	end

	// One idle cycle after each accept, so a request still held at that edge
	// is never issued twice
	assign take = cmd_valid_i && !s.accept && legal;

	always_comb begin
		next_s = s;
		next_s.pins = PINS_DESEL;
		next_s.accept = take;
		next_s.write_start = 1'b0;
		next_s.overdue = overdue_b;
		if (s.since_ref != SAT4) begin
			next_s.since_ref = s.since_ref + 4'h1;
		end
		if (s.since_mrs != SAT4) begin
			next_s.since_mrs = s.since_mrs + 4'h1;
		end
		if (s.since_act != SAT4) begin
			next_s.since_act = s.since_act + 4'h1;
		end
		next_s.faw = {s.faw[FAW_CYC-2:0], take && (cmd_i == CMD_ACT)};
		if (take) begin
			next_s.ba = bank_i;
			next_s.addr = addr_i;
			unique case (cmd_i)
				CMD_NOP: next_s.pins = PINS_NOP;
				CMD_ACT: begin
					next_s.pins = PINS_ACT;
					next_s.since_act = 4'h1;
				end
				CMD_READ: next_s.pins = PINS_READ;
				// Strobe window is opened on the command edge itself, zero offset
				CMD_WRITE: begin
					next_s.pins = PINS_WRITE;
					next_s.write_start = 1'b1;
				end
				CMD_PRE: next_s.pins = PINS_PRE;
				CMD_REF: begin
					next_s.pins = PINS_REF;
					next_s.since_ref = 4'h1;
				end
				CMD_MRS: begin
					next_s.pins = PINS_MRS;
					next_s.since_mrs = 4'h1;
				end
				default: next_s.pins = PINS_DESEL;
			endcase
		end
		// Interval timer restarts free-running; a late refresh is never forgiven
		if (take && cmd_i == CMD_REF) begin
			next_s.refresh_due = 1'b0;
		end
		if (s.refi == REFI_CYC - 9'h001) begin
			next_s.refi = 9'h000;
			next_s.refresh_due = 1'b1;
		end else begin
			next_s.refi = s.refi + 9'h001;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s <= '{pins: PINS_DESEL, ba: 2'h0, addr: 13'h0000, accept: 1'b0,
				write_start: 1'b0, refresh_due: 1'b0, overdue: 4'h0,
				since_ref: SAT4, since_mrs: SAT4, since_act: SAT4,
				faw: '0, refi: 9'h000};
		end else begin
			s <= next_s;
		end
	end

	assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = s.pins;
	assign ba_o = s.ba;
	assign addr_o = s.addr;
	assign cmd_accept_o = s.accept;
	assign write_start_o = s.write_start;
	assign refresh_due_o = s.refresh_due;
	assign row_overdue_o = s.overdue;

	logic iss_act;
	logic iss_ref;
	logic iss_mrs;
	logic iss_rw;
	assign iss_act = s.pins == PINS_ACT;
	assign iss_ref = s.pins == PINS_REF;
	assign iss_mrs = s.pins == PINS_MRS;
	assign iss_rw = (s.pins == PINS_READ) || (s.pins == PINS_WRITE);

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	ck_period_a: assert property (1'b1 |-> CK_LEGAL)
		else $error("device clock period out of range");
	refresh_gap_a: assert property (iss_ref |=> !(iss_act || iss_ref) [*5])
		else $error("activate or refresh too soon after refresh");
	refi_due_a: assert property ((s.refi == REFI_CYC - 9'h001) |=> refresh_due_o)
		else $error("refresh interval expired without flag");
	due_clear_a: assert property (iss_ref && $past(cmd_i == CMD_REF) && s.refi != 9'h000
		|-> !refresh_due_o)
		else $error("refresh did not clear due flag");
	access_gap_a: assert property (iss_rw |-> open_b[ba_o] && !$past(iss_act))
		else $error("access too soon after activate");
	row_cycle_a: assert property (iss_act |=> !(iss_act && ba_o == $past(ba_o)) [*2])
		else $error("same bank activated inside row cycle");
	mode_gap_a: assert property (iss_mrs |=> cs_n_o)
		else $error("command too soon after mode set");
	faw_count_a: assert property (iss_act |-> s.faw[0] && $countones(s.faw) <= FAW_LIMIT)
		else $error("too many activates in window");
	accept_pin_a: assert property (cmd_accept_o |-> !cs_n_o ##1 (!cmd_accept_o && cs_n_o))
		else $error("accept not tied to a single issued command");
	write_strobe_a: assert property (write_start_o |-> (s.pins == PINS_WRITE))
		else $error("write strobe start off its command edge");
	overdue_a: assert property ((|row_overdue_o) |-> ((|open_b) || $past(|open_b)))
		else $error("overdue flag on a closed bank");

	act_read_c: cover property (iss_act ##[1:8] iss_rw);
	refresh_c: cover property (iss_ref ##[6:20] iss_act);
	mode_set_c: cover property (iss_mrs ##2 !cs_n_o);
	due_c: cover property ($rose(refresh_due_o));

endmodule

// File: tb/ddr2_device_model.sv
`timescale 1ns/1ps
module ddr2_device_model import ddr2_guard_pkg::*; (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Command pins, bank and address
	input  wire logic [3:0]  pins_i,
	input  wire logic [1:0]  ba_i,
	input  wire logic [12:0] addr_i,
	// Spacing faults seen
	output int               faults_o
);
	int       cyc;
	int       t_ref;
	int       t_any;
	int       t_act[NUM_BANKS];
	int       t_pre[NUM_BANKS];
	int       acts[$];
	bit [3:0] open;

	task automatic need(input bit ok);
		if (!ok)
			faults_o++;
	endtask

	// Ages start large so the first commands after reset count as legal
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			cyc = 1000;
			t_ref = 0;
			t_any = 0;
			t_act = '{default: 0};
			t_pre = '{default: 0};
			acts.delete();
			open = 4'h0;
			faults_o = 0;
		end else begin
			cyc++;
			case (pins_i)
				PINS_ACT: begin
					need(!open[ba_i] && cyc - t_pre[ba_i] >= RP_CYC);
					need(cyc - t_act[ba_i] >= RC_CYC);
					need(cyc - t_any >= RRD_CYC && cyc - t_ref >= RFC_CYC);
					if (acts.size() == FAW_LIMIT)
						need(cyc - acts.pop_front() >= FAW_CYC);
					acts.push_back(cyc);
					open[ba_i] = 1'b1;
					t_act[ba_i] = cyc;
					t_any = cyc;
				end
				PINS_READ, PINS_WRITE: need(open[ba_i] && cyc - t_act[ba_i] >= RCD_CYC);
				PINS_PRE: begin
					for (int b = 0; b < NUM_BANKS; b++) begin
						if (open[b] && (b == ba_i || addr_i[PRE_ALL_BIT])) begin
							need(cyc - t_act[b] >= RAS_CYC);
							open[b] = 1'b0;
							t_pre[b] = cyc;
						end
					end
				end
				PINS_REF: begin
					need(open == 4'h0 && cyc - t_ref >= RFC_CYC);
					t_ref = cyc;
				end
				default: ;
			endcase
		end
	end
endmodule

// File: tb/ddr2_command_timing_guard_tb.sv
`timescale 1ns/1ps
module ddr2_command_timing_guard_tb import ddr2_guard_pkg::*; ;
	typedef struct packed {
		logic [3:0]  pins;
		logic [1:0]  ba;
		logic [12:0] addr;
		logic        wr;
		logic        full;
	} note_t;
	logic        clk;
	logic        rst;
	logic        cmd_valid;
	cmd_t        cmd;
	logic [1:0]  bank, ba, rb;
	logic [12:0] addr, addr_q, ra;
	logic        accept, cs_n, ras_n, cas_n, we_n, write_start, refresh_due;
	logic [3:0]  row_overdue;
	logic [3:0]  pin_map [7] = '{PINS_NOP, PINS_ACT, PINS_READ, PINS_WRITE,
		PINS_PRE, PINS_REF, PINS_MRS};
	note_t       notes[$];
	note_t       note;
	int          faults, t_acc, t_prev, t_due;
	int          cyc = 0;
	int          miscompares = 0;
	int          checks = 0;
	int          seed = 60;

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	ddr2_command_timing_guard i_ddr2_command_timing_guard (
		.ref_clk_i(clk), .reset_i(rst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.bank_i(bank), .addr_i(addr), .cmd_accept_o(accept), .cs_n_o(cs_n),
		.ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr_q),
		.write_start_o(write_start), .refresh_due_o(refresh_due), .row_overdue_o(row_overdue)
	);

	ddr2_device_model i_ddr2_device_model (
		.ref_clk_i(clk), .reset_i(rst), .pins_i({cs_n, ras_n, cas_n, we_n}),
		.ba_i(ba), .addr_i(addr_q), .faults_o(faults)
	);

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Request held until accepted, dropped in the accept cycle
	task automatic issue(input cmd_t c, input logic [1:0] b, input logic [12:0] a);
		int n = 0;
		notes.push_back({pin_map[c], b, a, c == CMD_WRITE, c != CMD_REF && c != CMD_NOP});
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = c;
		bank = b;
		addr = a;
		do begin
			@(negedge clk);
			n++;
		end while (accept !== 1'b1 && n < 50);
		cmd_valid = 1'b0;
		t_prev = t_acc;
		t_acc = cyc;
		check("cmd_accept_o", 1, accept);
	endtask

	task automatic wait_due();
		int n = 0;
		while (refresh_due !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		check("refresh_due_o rise", 1, refresh_due);
	endtask

	always @(negedge clk) begin
		if (!rst && accept === 1'b1) begin
			note = notes.pop_front();
			check("command pins", note.pins, {cs_n, ras_n, cas_n, we_n});
			check("write_start_o", note.wr, write_start);
			if (note.full)
				check("bank and address", {note.ba, note.addr}, {ba, addr_q});
		end else if (!rst)
			check("idle pins", {PINS_DESEL, 1'b0}, {cs_n, ras_n, cas_n, we_n, write_start});
	end

	// Longest test holds a row open about 3500 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		cmd_valid = 1'b0;
		cmd = CMD_NOP;
		bank = 2'h0;
		addr = 13'h0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check("refresh_due_o", 0, refresh_due);
		check("row_overdue_o", 0, row_overdue);
		$display("test reset done");
		issue(CMD_MRS, 2'h0, 13'h0042);
		issue(CMD_NOP, 2'h0, 13'h0);
		issue(CMD_ACT, 2'h1, 13'h0123);
		issue(CMD_WRITE, 2'h1, 13'h0008);
		issue(CMD_READ, 2'h1, 13'h0010);
		issue(CMD_PRE, 2'h1, 13'h0);
		$display("test command walk done");
		issue(CMD_REF, 2'h0, 13'h0);
		issue(CMD_ACT, 2'h0, 13'h0777);
		check("ref to act gap", (RFC_PS + REF_CLK_PS - 1) / REF_CLK_PS, t_acc - t_prev);
		issue(CMD_PRE, 2'h0, 13'h0);
		check("act to pre gap", (RAS_PS + REF_CLK_PS - 1) / REF_CLK_PS, t_acc - t_prev);
		$display("test spacing done");
		repeat (12) begin
			rb = 2'($random(seed));
			ra = 13'($random(seed));
			issue(CMD_ACT, rb, ra);
			issue(CMD_WRITE, rb, ra);
			issue(CMD_READ, rb, ra);
			issue(CMD_PRE, rb, ra);
			issue(CMD_REF, rb, ra);
		end
		$display("test random done");
		wait_due();
		t_due = cyc;
		issue(CMD_REF, 2'h0, 13'h0);
		check("refresh_due_o", 0, refresh_due);
		wait_due();
		check("refresh interval", REFI_PS / REF_CLK_PS, cyc - t_due);
		$display("test refresh done");
		issue(CMD_ACT, 2'h2, 13'h0);
		repeat (3490) @(negedge clk);
		check("row_overdue_o", 0, row_overdue);
		repeat (20) @(negedge clk);
		check("row_overdue_o", 4'h4, row_overdue);
		issue(CMD_PRE, 2'h2, 13'h0);
		@(negedge clk);
		check("row_overdue_o", 0, row_overdue);
		$display("test overdue done");
		cmd_valid = 1'b1;
		cmd = cmd_t'(3'h7);
		repeat (10) @(negedge clk);
		cmd_valid = 1'b0;
		check("model faults", 0, faults);
		$display("test refused code done");
		wrap_up();
	end
endmodule
